// *** dv/line_side_model.sv ***
// Line-side model: transmit pulse activity and receive loop-code patterns
`timescale 1ns/1ns
`default_nettype none
module line_side_model #(
   parameter int TICK_DIV = 4
)(
   input  wire logic       i_clock,
   input  wire logic       i_reset_n,
   input  wire logic       i_tx_active,
   input  wire logic [1:0] i_rx_pattern,
   output logic            o_tx_tick,
   output logic            o_tx_pos,
   output logic            o_tx_neg,
   output logic            o_rx_tick,
   output logic            o_rx_data
);
   int unsigned div;
   int unsigned phase;
   int unsigned period;
   logic        mark;

   // Pattern 0 is random traffic, 1 repeats 00001, 2 repeats 001
   assign period = (i_rx_pattern == 2'h1) ? line_alarm_pkg::UP_PERIOD
                                          : line_alarm_pkg::DOWN_PERIOD;

   always @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         div       <= 0;
         phase     <= 0;
         mark      <= 1'b0;
         o_tx_tick <= 1'b0;
         o_tx_pos  <= 1'b0;
         o_tx_neg  <= 1'b0;
         o_rx_tick <= 1'b0;
         o_rx_data <= 1'b0;
      end
      else
      begin
         div       <= (div == TICK_DIV - 1) ? 0 : div + 1;
         o_tx_tick <= (div == 0);
         o_rx_tick <= (div == 2);
         // Alternate marks so the output is truly bipolar
         o_tx_pos  <= i_tx_active && (div == 0) && mark;
         o_tx_neg  <= i_tx_active && (div == 0) && !mark;
         if (div == 0 && i_tx_active)
            mark <= !mark;
         if (div == 1)
         begin
            phase     <= (phase >= period - 1) ? 0 : phase + 1;
            o_rx_data <= (i_rx_pattern == 2'h0) ? 1'($urandom)
                                                : (phase >= period - 1);
         end
      end
   end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the line alarm status block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        clk;
   logic        rst_n;
   logic        rd;
   logic        wr;
   logic [13:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [3:0]  be;
   logic        wait_req;
   logic        loopback;
   logic        irq;
   logic        tx_tick;
   logic        tx_pos;
   logic        tx_neg;
   logic        rx_tick;
   logic        rx_data;
   logic        tx_active;
   logic [1:0]  pattern;
   logic [4:0]  wr_ptr;
   logic [4:0]  rd_ptr;
   logic        lost;
   logic        locked;
   logic [7:0]  got;
   logic [7:0]  en;
   logic [7:0]  acc;
   logic [7:0]  prev;
   logic [7:0]  exp;
   int          mismatches;
   int          compares;
   int          cycles;

   line_alarm_status #(.HOLD_CYCLES(32'd50)) uut (
      .I_CLOCK(clk), .I_RESET_N(rst_n), .I_ADDRESS(addr), .I_READ(rd),
      .I_WRITE(wr), .I_WRITEDATA(wdata), .I_BYTEENABLE(be),
      .O_READDATA(rdata), .O_WAITREQUEST(wait_req),
      .I_TX_BIT_TICK(tx_tick), .I_TX_LINE_POS(tx_pos),
      .I_TX_LINE_NEG(tx_neg), .I_RX_BIT_TICK(rx_tick), .I_RX_DATA(rx_data),
      .I_JA_WR_PTR(wr_ptr), .I_JA_RD_PTR(rd_ptr),
      .I_RX_SIGNAL_LOST(lost), .I_TEST_PATTERN_LOCKED(locked),
      .O_REMOTE_LOOPBACK(loopback), .O_IRQ(irq));

   line_side_model line (
      .i_clock(clk), .i_reset_n(rst_n), .i_tx_active(tx_active),
      .i_rx_pattern(pattern), .o_tx_tick(tx_tick), .o_tx_pos(tx_pos),
      .o_tx_neg(tx_neg), .o_rx_tick(rx_tick), .o_rx_data(rx_data));

   // ----------------------------------------------------------------
   // Bus and check helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e)
      begin
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
         mismatches++;
      end
   endtask

   task automatic bus_wait();
      @(negedge clk);
      while (wait_req !== 1'b0)
         @(negedge clk);
      @(posedge clk);
   endtask

   task automatic bus_rd(input logic [11:0] idx, output logic [7:0] d);
      @(posedge clk);
      addr <= {idx, 2'b00};
      rd   <= 1'b1;
      bus_wait();
      d = rdata[7:0];
      rd <= 1'b0;
   endtask

   task automatic bus_wr(input logic [11:0] idx, input logic [7:0] d,
                         input logic [3:0] b);
      @(posedge clk);
      addr  <= {idx, 2'b00};
      wdata <= {24'h0, d};
      be    <= b;
      wr    <= 1'b1;
      bus_wait();
      wr <= 1'b0;
   endtask

   // Polls a status bit; gives up after a bounded number of reads
   task automatic poll(input int b, input logic v);
      int k;
      k = 0;
      bus_rd(line_alarm_pkg::STATUS_IDX, got);
      while (got[b] !== v && k < 300)
      begin
         bus_rd(line_alarm_pkg::STATUS_IDX, got);
         k++;
      end
      chk({7'h0, got[b]}, {7'h0, v});
   endtask

   function automatic logic near(input logic [4:0] w, input logic [4:0] r);
      logic [4:0] d;
      d = w - r;
      return (d <= 5'd3) || (d >= 5'd29);
   endfunction

   task automatic conclude();
      if (mismatches == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Clock, timeout and main sequence
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         mismatches++;
         conclude();
      end
   end

   initial
   begin
      rst_n = 1'b0; rd = 1'b0; wr = 1'b0; addr = '0; wdata = '0;
      be = 4'hf; tx_active = 1'b1; pattern = 2'h0; wr_ptr = 5'h00;
      rd_ptr = 5'h10; lost = 1'b1; locked = 1'b0; cycles = 0;
      mismatches = 0; compares = 0;
      void'($urandom(32'hfb22));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         bus_rd(line_alarm_pkg::MODE_IDX + 12'(i), got);
         chk(got, 8'h00);
      end
      bus_rd(12'h010, got);
      chk(got, 8'h00);
      bus_wr(line_alarm_pkg::ENABLE_IDX, 8'h6b, 4'h0);
      bus_rd(line_alarm_pkg::ENABLE_IDX, got);
      chk(got, 8'h00);
      bus_wr(line_alarm_pkg::MODE_IDX, 8'h01, 4'hf);
      bus_wr(line_alarm_pkg::STATUS_IDX, 8'hff, 4'hf);
      bus_rd(line_alarm_pkg::STATUS_IDX, got);
      chk(got, 8'h02);
      bus_rd(line_alarm_pkg::CHANGE_IDX, got);
      prev = 8'h02;
      acc = 8'h00;
      for (int i = 0; i < 40; i++)
      begin
         en = 8'($urandom) & line_alarm_pkg::EVENT_MASK;
         bus_wr(line_alarm_pkg::ENABLE_IDX, en, 4'hf);
         bus_rd(line_alarm_pkg::ENABLE_IDX, got);
         chk(got, en);
         exp = 8'($urandom);
         wr_ptr <= exp[4:0];
         rd_ptr <= exp[4:0] + 5'($urandom_range(0, 7)) - 5'd4;
         lost   <= exp[5];
         locked <= exp[6];
         repeat (2) @(posedge clk);
         exp = {2'b00, near(wr_ptr, rd_ptr), 3'b000, lost, locked};
         acc = acc | (exp ^ prev);
         prev = exp;
         bus_rd(line_alarm_pkg::STATUS_IDX, got);
         chk(got, exp);
         chk({7'h0, irq}, {7'h0, |(acc & en)});
         bus_rd(line_alarm_pkg::CHANGE_IDX, got);
         chk(got, acc);
         acc = 8'h00;
         bus_rd(line_alarm_pkg::CHANGE_IDX, got);
         chk(got, 8'h00);
         chk({7'h0, irq}, 8'h00);
      end
      // Drive alarm: exact count of silent ticks, watched on the interrupt
      bus_wr(line_alarm_pkg::ENABLE_IDX, 8'h40, 4'hf);
      tx_active <= 1'b0;
      for (int n = 0; n < 128; n++)
      begin
         @(negedge clk);
         while (!(tx_tick && !tx_pos && !tx_neg))
            @(negedge clk);
         @(negedge clk);
         if (n == 126)
            chk({7'h0, irq}, 8'h00);
      end
      chk({7'h0, irq}, 8'h01);
      bus_rd(line_alarm_pkg::STATUS_IDX, got);
      chk(got, prev | 8'h40);
      bus_rd(line_alarm_pkg::CHANGE_IDX, got);
      chk(got, 8'h40);
      tx_active <= 1'b1;
      repeat (8) @(posedge clk);
      bus_rd(line_alarm_pkg::STATUS_IDX, got);
      chk(got, prev);
      bus_rd(line_alarm_pkg::CHANGE_IDX, got);
      chk(got, 8'h40);
      // Manual loop-code modes, each first offered the wrong pattern
      bus_wr(line_alarm_pkg::ENABLE_IDX, 8'h08, 4'hf);
      for (int m = 1; m <= 2; m++)
      begin
         bus_wr(line_alarm_pkg::MODE_IDX, {m[1:0], 6'h01}, 4'hf);
         pattern <= 2'(3 - m);
         repeat (300) @(posedge clk);
         bus_rd(line_alarm_pkg::STATUS_IDX, got);
         chk(got & 8'h08, 8'h00);
         pattern <= m[1:0];
         poll(3, 1'b1);
         chk({7'h0, irq}, 8'h01);
         bus_rd(line_alarm_pkg::CHANGE_IDX, got);
         chk(got, 8'h08);
         pattern <= 2'h0;
         poll(3, 1'b0);
         bus_rd(line_alarm_pkg::CHANGE_IDX, got);
         chk(got, 8'h08);
      end
      // Automatic mode entered while a manual detection stands
      bus_wr(line_alarm_pkg::MODE_IDX, 8'h41, 4'hf);
      pattern <= 2'h1;
      poll(3, 1'b1);
      bus_wr(line_alarm_pkg::MODE_IDX, 8'hc1, 4'hf);
      bus_rd(line_alarm_pkg::STATUS_IDX, got);
      chk(got & 8'h08, 8'h00);
      poll(3, 1'b1);
      chk({7'h0, loopback}, 8'h01);
      pattern <= 2'h0;
      repeat (300) @(posedge clk);
      bus_rd(line_alarm_pkg::STATUS_IDX, got);
      chk({6'h0, loopback, got[3]}, 8'h03);
      bus_rd(line_alarm_pkg::CHANGE_IDX, got);
      pattern <= 2'h2;
      poll(3, 1'b0);
      chk({6'h0, irq, loopback}, 8'h02);
      pattern <= 2'h1;
      poll(3, 1'b1);
      bus_wr(line_alarm_pkg::MODE_IDX, 8'h01, 4'hf);
      repeat (300) @(posedge clk);
      bus_rd(line_alarm_pkg::STATUS_IDX, got);
      chk({6'h0, loopback, got[3]}, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire

// *** src/line_alarm_pkg.sv ***
// Constants for the line alarm status and change-latch block
//
// Operation
// - No bipolar pulse on either transmit output for 128 bit periods declares drive alarm.
// - Any bipolar pulse on the transmit output clears the drive alarm at once.
// - Status register bit 6 shows drive alarm read-only; bit 7 reads zero.
// - FIFO-limit bit 5 is high while jitter FIFO pointers lie within three bits.
// - Each transition of drive, FIFO, signal-lost or pattern-lock status raises an enabled interrupt.
// - Manual loop-up mode sets loop-code bit after 00001 repeats beyond five seconds.
// - Manual loop-up mode drops loop-code bit as soon as the pattern stops.
// - Manual loop-down mode sets loop-code bit after 001 beyond five seconds, clears on stop.
// - In manual modes every loop-code transition raises an interrupt when enabled.
// - Entering automatic mode clears loop-code bit and starts searching for loop-up.
// - Automatic loop-up beyond five seconds sets bit, starts remote loopback, seeks loop-down.
// - Automatic mode keeps loop-code bit high while remote loopback stays active.
// - Loop-down beyond five seconds ends loopback, clears bit, raises enabled interrupt.
// - A read-only status bit shows receive loss of signal.
// - A read-only status bit shows lock to the quasi-random test pattern.
// - Status and change registers work only in single-rail mode; the enable register works in either mode.
// - Change bits 6, 5, 3 latch any change of their status bits since last read.
// - Change bits clear when the change register is read.
// - Change bits 1 and 0 latch signal-lost and pattern-lock changes, clear on read.
// - Loop mode 00 disables loop-code detection; loop-code bit stays inactive.
// - Enable register holds enables in bits 6, 5, 3, 1 and 0.
package line_alarm_pkg;

   // -----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [11:0] MODE_IDX   = 12'hf03;
   localparam logic [11:0] ENABLE_IDX = 12'hf04;
   localparam logic [11:0] STATUS_IDX = 12'hf05;
   localparam logic [11:0] CHANGE_IDX = 12'hf06;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int DRIVE_BIT   = 6;
   localparam int FIFO_BIT    = 5;
   localparam int LOOP_BIT    = 3;
   localparam int LOST_BIT    = 1;
   localparam int PATTERN_BIT = 0;
   localparam int MODE_HI_BIT = 7;
   localparam int MODE_LO_BIT = 6;
   localparam int RAIL_BIT    = 0;

   localparam logic [7:0] EVENT_MASK  = 8'h6b;
   localparam logic [7:0] MODE_MASK   = 8'hc1;
   localparam logic [7:0] RESET_VALUE = 8'h00;

   // -----------------------------------------------------------------
   // Loop-code modes and patterns
   // -----------------------------------------------------------------
   localparam logic [1:0] MODE_OFF  = 2'h0;
   localparam logic [1:0] MODE_UP   = 2'h1;
   localparam logic [1:0] MODE_DOWN = 2'h2;
   localparam logic [1:0] MODE_AUTO = 2'h3;
   localparam int UP_PERIOD   = 5;
   localparam int DOWN_PERIOD = 3;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int  CLOCK_HZ    = 100000000;
   localparam int  HOLD_S      = 5;
   localparam longint HOLD_CYCLES_L = 64'(HOLD_S) * 64'(CLOCK_HZ);
   localparam int  DRIVE_BITS  = 128;
   localparam int  FIFO_LIMIT  = 3;

   typedef enum logic [1:0] {
      LC_OFF,
      LC_MANUAL,
      LC_AUTO_UP,
      LC_AUTO_LOOP
   } loop_state_type;

endpackage

// *** src/line_alarm_status.sv ***
// Line alarm status, change latches and loop-code detector
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module line_alarm_status #(
   parameter int          PTR_W       = 5,
   parameter int          DRIVE_BITS  = line_alarm_pkg::DRIVE_BITS,
   parameter logic [31:0] HOLD_CYCLES =
      32'(line_alarm_pkg::HOLD_CYCLES_L)
)(
   input  wire logic             I_CLOCK,
   input  wire logic             I_RESET_N,
   input  wire logic [13:0]      I_ADDRESS,
   input  wire logic             I_READ,
   input  wire logic             I_WRITE,
   input  wire logic [31:0]      I_WRITEDATA,
   input  wire logic [3:0]       I_BYTEENABLE,
   output var  logic [31:0]      O_READDATA,
   output var  logic             O_WAITREQUEST,
   input  wire logic             I_TX_BIT_TICK,
   input  wire logic             I_TX_LINE_POS,
   input  wire logic             I_TX_LINE_NEG,
   input  wire logic             I_RX_BIT_TICK,
   input  wire logic             I_RX_DATA,
   input  wire logic [PTR_W-1:0] I_JA_WR_PTR,
   input  wire logic [PTR_W-1:0] I_JA_RD_PTR,
   input  wire logic             I_RX_SIGNAL_LOST,
   input  wire logic             I_TEST_PATTERN_LOCKED,
   output var  logic             O_REMOTE_LOOPBACK,
   output var  logic             O_IRQ
);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (PTR_W < 3 || PTR_W > 16)
      $error("PTR_W out of range");
   if (DRIVE_BITS < 2 || DRIVE_BITS > 65535)
      $error("DRIVE_BITS out of range");
   if (HOLD_CYCLES < 32'h2)
      $error("HOLD_CYCLES too small");

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                         ack;
      logic [31:0]                  rdata;
      logic [7:0]                   enable;
      logic [7:0]                   mode;
      logic [15:0]                  idle_cnt;
      logic                         drive_alarm;
      logic                         fifo_limit;
      logic                         signal_lost;
      logic                         pattern_locked;
      line_alarm_pkg::loop_state_type loop_state;
      logic                         loop_code;
      logic                         loopback;
      logic [5:0]                   rx_shift;
      logic                         match;
      logic [31:0]                  hold_cnt;
      logic [7:0]                   change;
   } state_type;

   state_type state;
   state_type next_state;

   logic              request;
   logic              accept;
   logic [11:0]       index;
   logic              single_rail;
   logic [1:0]        loop_mode;
   logic              pulse_seen;
   logic [PTR_W-1:0]  diff_fw;
   logic [PTR_W-1:0]  diff_bw;
   logic              fifo_near;
   logic              target_down;
   logic              detected;
   logic [7:0]        status_now;
   logic [7:0]        status_next;
   logic [5:0]        shifted;
   logic              period_ok;

   assign request     = I_READ | I_WRITE;
   assign accept      = request & ~state.ack;
   assign index       = I_ADDRESS[13:2];
   assign single_rail = state.mode[line_alarm_pkg::RAIL_BIT];
   assign loop_mode   = state.mode[line_alarm_pkg::MODE_HI_BIT:
                                   line_alarm_pkg::MODE_LO_BIT];
   assign pulse_seen  = I_TX_LINE_POS | I_TX_LINE_NEG;
   assign diff_fw     = PTR_W'(I_JA_WR_PTR - I_JA_RD_PTR);
   assign diff_bw     = PTR_W'(I_JA_RD_PTR - I_JA_WR_PTR);
   assign fifo_near   = (diff_fw <= PTR_W'(line_alarm_pkg::FIFO_LIMIT)) ||
                        (diff_bw <= PTR_W'(line_alarm_pkg::FIFO_LIMIT));
   assign target_down = (loop_mode == line_alarm_pkg::MODE_DOWN) ||
                        (state.loop_state == line_alarm_pkg::LC_AUTO_LOOP);
   assign detected    = state.match && (state.hold_cnt == HOLD_CYCLES);
   assign shifted     = {state.rx_shift[4:0], I_RX_DATA};

   // Repeating pattern: period repeats and one mark per period
   always_comb
   begin
      if (target_down)
      begin
         period_ok = (shifted[0] == shifted[line_alarm_pkg::DOWN_PERIOD]) &&
                     ($countones(shifted[2:0]) == 1);
      end
      else
      begin
         period_ok = (shifted[0] == shifted[line_alarm_pkg::UP_PERIOD]) &&
                     ($countones(shifted[4:0]) == 1);
      end
   end

   always_comb
   begin
      status_now = line_alarm_pkg::RESET_VALUE;
      status_now[line_alarm_pkg::DRIVE_BIT]   = state.drive_alarm;
      status_now[line_alarm_pkg::FIFO_BIT]    = state.fifo_limit;
      status_now[line_alarm_pkg::LOOP_BIT]    = state.loop_code;
      status_now[line_alarm_pkg::LOST_BIT]    = state.signal_lost;
      status_now[line_alarm_pkg::PATTERN_BIT] = state.pattern_locked;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;

      // Bus: one wait cycle, then answer
      next_state.ack = accept;
      if (accept && I_READ)
      begin
         unique case (index)
            line_alarm_pkg::MODE_IDX:
               next_state.rdata = {24'h0, state.mode};
            line_alarm_pkg::ENABLE_IDX:
               next_state.rdata = {24'h0, state.enable};
            line_alarm_pkg::STATUS_IDX:
               next_state.rdata = {24'h0,
                  single_rail ? status_now : line_alarm_pkg::RESET_VALUE};
            line_alarm_pkg::CHANGE_IDX:
               next_state.rdata = {24'h0, state.change};
            default:
               next_state.rdata = 32'h0;
         endcase
      end
      if (accept && I_WRITE && I_BYTEENABLE[0])
      begin
         if (index == line_alarm_pkg::ENABLE_IDX)
            next_state.enable = I_WRITEDATA[7:0] &
                                line_alarm_pkg::EVENT_MASK;
         if (index == line_alarm_pkg::MODE_IDX)
            next_state.mode = I_WRITEDATA[7:0] & line_alarm_pkg::MODE_MASK;
      end

      // Transmit drive monitor
      if (pulse_seen)
      begin
         next_state.idle_cnt    = 16'h0;
         next_state.drive_alarm = 1'b0;
      end
      else if (I_TX_BIT_TICK && !state.drive_alarm)
      begin
         next_state.idle_cnt = state.idle_cnt + 16'h1;
         if (state.idle_cnt == 16'(DRIVE_BITS - 1))
            next_state.drive_alarm = 1'b1;
      end

      next_state.fifo_limit     = fifo_near;
      next_state.signal_lost    = I_RX_SIGNAL_LOST;
      next_state.pattern_locked = I_TEST_PATTERN_LOCKED;

      // Receive pattern match, judged once per bit
      if (I_RX_BIT_TICK)
      begin
         next_state.rx_shift = shifted;
         next_state.match    = period_ok;
      end
      if (!next_state.match)
         next_state.hold_cnt = 32'h0;
      else if (state.hold_cnt != HOLD_CYCLES)
         next_state.hold_cnt = state.hold_cnt + 32'h1;

      // Loop-code control
      if (!single_rail || loop_mode == line_alarm_pkg::MODE_OFF)
      begin
         next_state.loop_state = line_alarm_pkg::LC_OFF;
         next_state.loop_code  = 1'b0;
         next_state.loopback   = 1'b0;
      end
      else if (loop_mode != line_alarm_pkg::MODE_AUTO)
      begin
         next_state.loop_state = line_alarm_pkg::LC_MANUAL;
         next_state.loopback   = 1'b0;
         next_state.loop_code  = detected;
      end
      else
      begin
         unique case (state.loop_state)
            line_alarm_pkg::LC_OFF,
            line_alarm_pkg::LC_MANUAL:
            begin
               next_state.loop_state = line_alarm_pkg::LC_AUTO_UP;
               next_state.loop_code  = 1'b0;
               next_state.hold_cnt   = 32'h0;
               next_state.match      = 1'b0;
            end
            line_alarm_pkg::LC_AUTO_UP:
            begin
               if (detected)
               begin
                  next_state.loop_state = line_alarm_pkg::LC_AUTO_LOOP;
                  next_state.loop_code  = 1'b1;
                  next_state.loopback   = 1'b1;
                  next_state.hold_cnt   = 32'h0;
                  next_state.match      = 1'b0;
               end
            end
            line_alarm_pkg::LC_AUTO_LOOP:
            begin
               next_state.loop_code = 1'b1;
               if (detected)
               begin
                  next_state.loop_state = line_alarm_pkg::LC_AUTO_UP;
                  next_state.loop_code  = 1'b0;
                  next_state.loopback   = 1'b0;
                  next_state.hold_cnt   = 32'h0;
                  next_state.match      = 1'b0;
               end
            end
         endcase
      end

      // Change latches: a read clears, a new change wins
      if (accept && I_READ && index == line_alarm_pkg::CHANGE_IDX)
         next_state.change = line_alarm_pkg::RESET_VALUE;
      status_next = line_alarm_pkg::RESET_VALUE;
      status_next[line_alarm_pkg::DRIVE_BIT]   = next_state.drive_alarm;
      status_next[line_alarm_pkg::FIFO_BIT]    = next_state.fifo_limit;
      status_next[line_alarm_pkg::LOOP_BIT]    = next_state.loop_code;
      status_next[line_alarm_pkg::LOST_BIT]    = next_state.signal_lost;
      status_next[line_alarm_pkg::PATTERN_BIT] = next_state.pattern_locked;
      if (single_rail)
         next_state.change = next_state.change |
            ((status_next ^ status_now) &
             line_alarm_pkg::EVENT_MASK);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLOCK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         state <= '0;
      else
         state <= next_state;
   end

   assign O_READDATA        = state.rdata;
   assign O_WAITREQUEST     = request & ~state.ack;
   assign O_REMOTE_LOOPBACK = state.loopback;
   assign O_IRQ             = |(state.change & state.enable);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_RESET_N);

   logic change_read;
   logic status_read;
   assign change_read = accept && I_READ &&
                        index == line_alarm_pkg::CHANGE_IDX;
   assign status_read = accept && I_READ &&
                        index == line_alarm_pkg::STATUS_IDX;

   sequence seq_idle_last;
      I_TX_BIT_TICK && !pulse_seen && !state.drive_alarm &&
      state.idle_cnt == 16'(DRIVE_BITS - 1);
   endsequence

   sequence seq_enter_auto;
      single_rail && loop_mode == line_alarm_pkg::MODE_AUTO &&
      state.loop_state == line_alarm_pkg::LC_MANUAL;
   endsequence

   AST_DRIVE_SET: assert property (seq_idle_last |=> state.drive_alarm)
      else $error("drive alarm not declared after idle run");

   AST_DRIVE_CLEAR: assert property (pulse_seen |=> !state.drive_alarm)
      else $error("drive alarm not cleared by pulse");

   AST_STATUS_RSVD: assert property ($past(status_read) |->
      state.rdata[31:7] == 25'h0)
      else $error("reserved status bits not zero");

   AST_FIFO_NEAR: assert property (fifo_near |=> state.fifo_limit)
      else $error("fifo limit flag missed");

   AST_DRIVE_CHANGE: assert property (single_rail &&
      ($past(state.drive_alarm) != state.drive_alarm) && !$past(change_read)
      |-> state.change[line_alarm_pkg::DRIVE_BIT])
      else $error("drive change not latched");

   AST_READ_CLEAR: assert property (change_read &&
      status_next == status_now |=> state.change == 8'h0)
      else $error("change register not cleared by read");

   AST_AUTO_ENTRY: assert property (seq_enter_auto |=>
      !state.loop_code ##1 !state.loop_code)
      else $error("loop code not cleared on auto entry");

   AST_LOOPBACK_CODE: assert property (state.loopback |->
      state.loop_code && state.loop_state == line_alarm_pkg::LC_AUTO_LOOP)
      else $error("loopback without loop code");

   AST_MODE_OFF: assert property ($past(loop_mode) == 2'h0 &&
      loop_mode == 2'h0 |-> !state.loop_code)
      else $error("loop code set while detection off");

   // An enable write may legally mask a pending change
   AST_IRQ_HOLD: assert property (O_IRQ && !change_read &&
      !(accept && I_WRITE) && $stable(state.enable) |=> O_IRQ)
      else $error("interrupt dropped without read");

   AST_FIFO_CLEAR: assert property (!fifo_near |=> !state.fifo_limit)
      else $error("fifo limit flag not cleared");

   AST_INPUT_FOLLOW: assert property (1'b1 |=>
      state.signal_lost == $past(I_RX_SIGNAL_LOST) &&
      state.pattern_locked == $past(I_TEST_PATTERN_LOCKED))
      else $error("status bit does not follow its input");

   // ----------------------------------------------------------------
   // Loop-code checks
   // ----------------------------------------------------------------
   sequence seq_manual_mode;
      single_rail && (loop_mode == line_alarm_pkg::MODE_UP ||
                      loop_mode == line_alarm_pkg::MODE_DOWN);
   endsequence

   sequence seq_remote_arm;
      single_rail && loop_mode == line_alarm_pkg::MODE_AUTO &&
      state.loop_state == line_alarm_pkg::LC_AUTO_UP && detected;
   endsequence

   sequence seq_remote_end;
      single_rail && loop_mode == line_alarm_pkg::MODE_AUTO &&
      state.loop_state == line_alarm_pkg::LC_AUTO_LOOP && detected;
   endsequence

   AST_MANUAL_FOLLOW: assert property (seq_manual_mode |=>
      state.loop_code == $past(detected))
      else $error("manual loop code does not follow detector");

   AST_REMOTE_SET: assert property (seq_remote_arm |=>
      state.loopback && state.loop_code)
      else $error("remote loopback not started with loop code");

   AST_REMOTE_END: assert property (seq_remote_end |=>
      !state.loopback && !state.loop_code)
      else $error("remote loopback not ended by loop-down");

   AST_LOOP_CHANGE: assert property ($past(single_rail) &&
      state.loop_code != $past(state.loop_code) |->
      state.change[line_alarm_pkg::LOOP_BIT])
      else $error("loop code change not latched");

   AST_BUS_ANSWER: assert property (accept |=> !O_WAITREQUEST [*1])
      else $error("bus answer late");

endmodule
`default_nettype wire
